// File: rtl/reset_init_pkg.sv
package reset_init_pkg;

    // Quarter phase of the processor clock
    localparam logic [1:0]  FIRST_QUARTER       = 2'h0;
    localparam logic [1:0]  LAST_QUARTER        = 2'h3;
    localparam int          ALIGN_QUARTER_LIMIT = 10;

    // Sequencer counts, in local clock periods (four MCLK_I cycles each), except INIT_REFRESHES in refresh cycles
    localparam logic [2:0]  HOLD_LOCAL_MIN      = 3'h4;
    localparam logic [5:0]  INTRST_LOCAL        = 6'h22;
    localparam logic [3:0]  INIT_REFRESHES      = 4'h8;
    localparam logic [7:0]  REFRESH_BASE        = 8'h08;

    // Reset vector fetch and load values
    localparam logic [31:0] VEC_BIT_ADDR        = 32'hFFFF_FFE0;
    localparam logic [31:0] STATUS_RESET        = 32'h0000_0010;
    localparam logic [3:0]  STS_VEC_FETCH       = 4'hC;
    localparam logic [3:0]  CAS_ALL             = 4'h0;
    localparam logic [3:0]  CAS_LOW_HALF        = 4'hC;
    localparam logic [3:0]  CAS_NONE            = 4'hF;

    // Register offsets (byte addresses)
    localparam logic [7:0]  OFS_HOST_CTL        = 8'h00;
    localparam logic [7:0]  OFS_CONFIG          = 8'h04;
    localparam logic [7:0]  OFS_STATUS          = 8'h08;
    localparam logic [7:0]  OFS_PC              = 8'h0C;
    localparam logic [7:0]  OFS_REFRESH         = 8'h10;
    localparam logic [7:0]  OFS_SEQ             = 8'h14;
    localparam logic [7:0]  OFS_PRESENT         = 8'h18;

    // Field positions and reset values
    localparam int          HALT_BIT            = 15;
    localparam int          CFG_BYTE_ORDER      = 0;
    localparam int          CFG_LOCK            = 1;
    localparam logic [15:0] CFG_LOCK_MASK       = 16'h00FF;
    localparam logic [31:0] PRESENT_RESET       = 32'h0000_0000;

    typedef enum logic [2:0] {
        S_RESET  = 3'b000,
        S_INTRST = 3'b001,
        S_INIT   = 3'b010,
        S_HALT   = 3'b011,
        S_VEC    = 3'b100,
        S_RUN    = 3'b101
    } seq_state_t;

    typedef enum logic [3:0] {
        M_IDLE      = 4'b0000,
        M_REF_CAS   = 4'b0001,
        M_REF_RAS   = 4'b0010,
        M_REF_END   = 4'b0011,
        M_ADR       = 4'b0100,
        M_ROW       = 4'b0101,
        M_COL       = 4'b0110,
        M_PAGE      = 4'b0111,
        M_FETCH_END = 4'b1000
    } mem_state_t;

    typedef struct packed {
        logic        row_strobe;
        logic [3:0]  col_strobe;
        logic        write_enable;
        logic        transfer_output_enable;
        logic        buffer_dir_out;
        logic        buffer_dir_in;
        logic        address_latch_strobe;
        logic        host_interrupt_out;
        logic        bus_request_zero;
        logic        bus_request_one;
        logic        host_output_enable;
        logic        host_data_strobe;
        logic        emulation_pin_three;
        logic [12:0] row_col_addr_bus;
        logic        special_function_pin;
        logic        host_ready_out;
        logic        blanking_out;
    } pins_t;

    // Pin levels while reset is in force
    localparam pins_t PINS_RESET = '{host_ready_out: 1'b0, blanking_out: 1'b0,
                                     buffer_dir_in: 1'b0, default: '1};
    // Pins floated by the global output disable
    localparam pins_t GI_MASK = '{host_ready_out: 1'b0, blanking_out: 1'b0, host_interrupt_out: 1'b0,
                                  bus_request_zero: 1'b0, bus_request_one: 1'b0,
                                  emulation_pin_three: 1'b0, default: '1};

endpackage : reset_init_pkg

// File: rtl/reset_init_sequencer.sv
`timescale 1ns/10ps
module reset_init_sequencer
    import reset_init_pkg::*;
(
    // Clock and power-on reset
    input  wire logic        MCLK_I,
    input  wire logic        ARST_N_I,
    // Reset pin and straps
    input  wire logic        RESET_N_I,
    input  wire logic        HOST_CHIP_SELECT_N_I,
    input  wire logic        GLOBAL_OUTPUT_DISABLE_I,
    // Local memory inputs
    input  wire logic [31:0] LAD_I,
    input  wire logic        MEM_WAIT_N_I,
    input  wire logic        BUS16_I,
    // Register port
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [31:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [31:0] RDATA_O,
    // Memory and control pins
    output pins_t            PINS_O,
    output pins_t            PINS_OE_N_O,
    output logic      [31:0] LAD_O,
    output logic             LAD_OE_N_O,
    output logic      [2:0]  SYNC_OE_N_O,
    // Core handshake
    output logic             CPU_RUN_O,
    output logic             MEM_GRANT_O
);

    // Synchroniser, strap pipeline and quarter phase
    logic        rst_meta, rst_sync, rst_prev;
    logic        next_rst_meta, next_rst_sync, next_rst_prev;
    logic [2:0]  hcs_pipe, next_hcs_pipe;
    logic [1:0]  qphase, next_qphase;
    logic        rst_rise, local_tick;

    // Reset sequencer
    seq_state_t  seq_state, next_seq_state;
    logic [5:0]  cnt, next_cnt;
    logic [3:0]  inits, next_inits;
    logic [2:0]  held, next_held;
    logic        powered, next_powered;

    // Memory cycle engine
    mem_state_t  mem_state, next_mem_state;
    logic [7:0]  ref_cnt, next_ref_cnt, ref_limit;
    logic        ref_due, next_ref_due, ref_hit, ref_start;
    logic        half, next_half;
    logic [31:0] vec_word, next_vec_word;

    // Registers
    logic [15:0] host_ctl, next_host_ctl;
    logic [15:0] config_reg, next_config_reg;
    logic [31:0] status_word, next_status_word;
    logic [31:0] pc, next_pc;
    logic [3:0]  refresh_rate, next_refresh_rate;
    logic [31:0] present, next_present;
    logic [7:0]  lru, next_lru, lru_init;
    logic [31:0] next_rdata;
    logic        halt_flag, in_reset;

    // Pins
    pins_t       next_pins, next_pins_oe_n;
    logic [31:0] next_lad;
    logic        next_lad_oe_n, lad_drive, next_cpu_run;
    logic [12:0] row_addr, col_addr;

    assign rst_rise   = rst_sync & ~rst_prev;
    assign local_tick = (qphase == LAST_QUARTER);
    assign halt_flag  = host_ctl[HALT_BIT];
    assign in_reset   = (seq_state == S_RESET) || (seq_state == S_INTRST);
    assign ref_limit  = {1'b0, refresh_rate, 3'h0} + REFRESH_BASE;
    assign row_addr   = VEC_BIT_ADDR[29:17];
    assign col_addr   = VEC_BIT_ADDR[16:4] + {12'h000, next_half};

    // LRU stack reset order, entry i holds segment i
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lru
            assign lru_init[gi*2 +: 2] = 2'(gi);
        end
    endgenerate

    // Reset pin is registered twice before any edge detection
    always_comb begin
        next_rst_meta = RESET_N_I;
        next_rst_sync = rst_meta;
        next_rst_prev = rst_sync;
        next_hcs_pipe = {hcs_pipe[1:0], HOST_CHIP_SELECT_N_I};
        // Release realigns all peers sharing clock and reset
        next_qphase   = rst_rise ? FIRST_QUARTER : qphase + 2'h1;
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
            rst_prev <= 1'b0;
            hcs_pipe <= 3'h0;
            qphase   <= FIRST_QUARTER;
        end else begin
            rst_meta <= next_rst_meta;
            rst_sync <= next_rst_sync;
            rst_prev <= next_rst_prev;
            hcs_pipe <= next_hcs_pipe;
            qphase   <= next_qphase;
        end
    end

    // Reset sequence: hold, internal reset, init refresh, halt, vector, run
    always_comb begin
        next_seq_state = seq_state;
        next_cnt       = cnt;
        next_inits     = inits;
        next_held      = held;
        next_powered   = powered;
        if (!rst_sync) begin
            next_seq_state = S_RESET;
            if (seq_state != S_RESET) begin
                next_held = 3'h0;
            end else if (local_tick && held != HOLD_LOCAL_MIN) begin
                next_held = held + 3'h1;
            end
        end else begin
            case (seq_state)
                S_RESET: begin
                    next_powered = 1'b1;
                    next_cnt     = 6'h00;
                    next_inits   = 4'h0;
                    // Power-up release skips the internal reset state
                    next_seq_state = (powered && held == HOLD_LOCAL_MIN) ? S_INTRST : S_INIT;
                end
                S_INTRST: begin
                    if (local_tick) begin
                        if (cnt == INTRST_LOCAL - 6'h01) begin
                            next_seq_state = S_INIT;
                        end else begin
                            next_cnt = cnt + 6'h01;
                        end
                    end
                end
                S_INIT: begin
                    if (mem_state == M_REF_END) begin
                        if (inits == INIT_REFRESHES - 4'h1) begin
                            next_seq_state = halt_flag ? S_HALT : S_VEC;
                        end else begin
                            next_inits = inits + 4'h1;
                        end
                    end
                end
                S_HALT: begin
                    if (!halt_flag) begin
                        next_seq_state = S_VEC;
                    end
                end
                S_VEC: begin
                    if (mem_state == M_FETCH_END) begin
                        next_seq_state = S_RUN;
                    end
                end
                S_RUN: begin
                    next_seq_state = S_RUN;
                end
                default: begin
                    next_seq_state = S_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            seq_state <= S_RESET;
            cnt       <= 6'h00;
            inits     <= 4'h0;
            held      <= 3'h0;
            powered   <= 1'b0;
        end else begin
            seq_state <= next_seq_state;
            cnt       <= next_cnt;
            inits     <= next_inits;
            held      <= next_held;
            powered   <= next_powered;
        end
    end

    // Refresh timer and memory cycles; refresh beats the vector fetch
    always_comb begin
        next_mem_state = mem_state;
        next_ref_cnt   = ref_cnt;
        next_half      = half;
        next_vec_word  = vec_word;
        ref_hit        = 1'b0;
        ref_start      = 1'b0;
        if (seq_state == S_RESET) begin
            next_mem_state = M_IDLE; // No refresh while the pin is low
            next_ref_cnt   = 8'h00;
        end else begin
            if (local_tick) begin
                if (ref_cnt >= ref_limit - 8'h01) begin
                    next_ref_cnt = 8'h00;
                    ref_hit      = 1'b1;
                end else begin
                    next_ref_cnt = ref_cnt + 8'h01;
                end
            end
            case (mem_state)
                M_IDLE: begin
                    if (ref_due || seq_state == S_INIT) begin
                        next_mem_state = M_REF_CAS;
                        ref_start      = 1'b1;
                    end else if (seq_state == S_VEC) begin
                        next_mem_state = M_ADR;
                        next_half      = 1'b0;
                    end
                end
                M_REF_CAS: next_mem_state = M_REF_RAS;
                M_REF_RAS: next_mem_state = M_REF_END;
                M_REF_END: next_mem_state = M_IDLE;
                M_ADR:     next_mem_state = M_ROW;
                M_ROW:     next_mem_state = M_COL;
                M_COL: begin
                    // Wait states stretch the column phase
                    if (MEM_WAIT_N_I) begin
                        if (!BUS16_I) begin
                            next_vec_word  = LAD_I;
                            next_mem_state = M_FETCH_END;
                        end else if (!half) begin
                            next_vec_word[15:0] = LAD_I[15:0];
                            next_half           = 1'b1;
                            next_mem_state      = M_PAGE;
                        end else begin
                            next_vec_word[31:16] = LAD_I[15:0];
                            next_mem_state       = M_FETCH_END;
                        end
                    end
                end
                M_PAGE:      next_mem_state = M_COL; // Page-mode second column
                M_FETCH_END: next_mem_state = M_IDLE;
                default:     next_mem_state = M_IDLE;
            endcase
        end
        // A tick in the same cycle as a start is kept
        next_ref_due = (seq_state != S_RESET) && ((ref_due && !ref_start) || ref_hit);
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mem_state <= M_IDLE;
            ref_cnt   <= 8'h00;
            ref_due   <= 1'b0;
            half      <= 1'b0;
            vec_word  <= 32'h0000_0000;
        end else begin
            mem_state <= next_mem_state;
            ref_cnt   <= next_ref_cnt;
            ref_due   <= next_ref_due;
            half      <= next_half;
            vec_word  <= next_vec_word;
        end
    end

    // Register file: reset clear, vector load, software access
    always_comb begin
        next_host_ctl     = host_ctl;
        next_config_reg   = config_reg;
        next_status_word  = status_word;
        next_pc           = pc;
        next_refresh_rate = refresh_rate;
        next_present      = present;
        next_lru          = lru;
        next_rdata        = 32'h0000_0000;
        if (in_reset) begin
            next_host_ctl           = 16'h0000;
            next_host_ctl[HALT_BIT] = rst_rise ? hcs_pipe[2] : halt_flag;
            next_config_reg         = 16'h0000;
            next_status_word        = 32'h0000_0000;
            next_pc                 = 32'h0000_0000;
            next_refresh_rate       = 4'h0;
            next_present            = PRESENT_RESET;
            next_lru                = lru_init;
        end else begin
            if (WR_I) begin
                case (ADDR_I)
                    OFS_HOST_CTL: next_host_ctl = WDATA_I[15:0];
                    OFS_CONFIG: begin
                        if (config_reg[CFG_LOCK]) begin
                            next_config_reg = (WDATA_I[15:0] & ~CFG_LOCK_MASK)
                                            | (config_reg & CFG_LOCK_MASK);
                        end else begin
                            next_config_reg = WDATA_I[15:0];
                        end
                    end
                    OFS_REFRESH: next_refresh_rate = WDATA_I[3:0];
                    OFS_PRESENT: next_present = WDATA_I;
                    default: ;
                endcase
            end
            if (mem_state == M_FETCH_END) begin
                next_status_word    = STATUS_RESET;
                next_pc             = {vec_word[31:4], 4'h0};
                next_config_reg[3:0] = vec_word[3:0];
            end
        end
        if (RD_I) begin
            case (ADDR_I)
                OFS_HOST_CTL: next_rdata = {16'h0000, host_ctl};
                OFS_CONFIG:   next_rdata = {16'h0000, config_reg};
                OFS_STATUS:   next_rdata = status_word;
                OFS_PC:       next_rdata = pc;
                OFS_REFRESH:  next_rdata = {28'h0000000, refresh_rate};
                OFS_SEQ:      next_rdata = {16'h0000, lru, 1'b0, seq_state, 2'h0, qphase};
                OFS_PRESENT:  next_rdata = present;
                default:      next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            host_ctl     <= 16'h0000;
            config_reg   <= 16'h0000;
            status_word  <= 32'h0000_0000;
            pc           <= 32'h0000_0000;
            refresh_rate <= 4'h0;
            present      <= PRESENT_RESET;
            lru          <= 8'h00;
            RDATA_O      <= 32'h0000_0000;
        end else begin
            host_ctl     <= next_host_ctl;
            config_reg   <= next_config_reg;
            status_word  <= next_status_word;
            pc           <= next_pc;
            refresh_rate <= next_refresh_rate;
            present      <= next_present;
            lru          <= next_lru;
            RDATA_O      <= next_rdata;
        end
    end

    // Pin levels follow the next memory state so they line up with it
    always_comb begin
        next_pins                = PINS_RESET;
        next_pins.host_ready_out = (next_seq_state != S_RESET) && (next_seq_state != S_INTRST);
        next_lad                 = 32'h0000_0000;
        lad_drive                = 1'b0;
        case (next_mem_state)
            M_REF_CAS: next_pins.col_strobe = CAS_ALL;
            M_REF_RAS: begin
                next_pins.col_strobe = CAS_ALL;
                next_pins.row_strobe = 1'b0;
            end
            M_REF_END: next_pins.row_strobe = 1'b0;
            M_ADR, M_ROW: begin
                next_pins.address_latch_strobe = 1'b0;
                next_pins.row_strobe           = (next_mem_state == M_ADR);
                next_pins.row_col_addr_bus     = row_addr;
                next_lad                       = {VEC_BIT_ADDR[31:4], STS_VEC_FETCH};
                lad_drive                      = 1'b1;
            end
            M_COL, M_PAGE: begin
                next_pins.row_strobe       = 1'b0;
                next_pins.row_col_addr_bus = col_addr;
                next_pins.buffer_dir_in    = 1'b1; // Steer external buffers inward
                if (next_mem_state == M_COL) begin
                    next_pins.col_strobe = BUS16_I ? CAS_LOW_HALF : CAS_ALL;
                end else begin
                    next_pins.col_strobe = CAS_NONE;
                end
            end
            default: ;
        endcase
        next_pins_oe_n = GLOBAL_OUTPUT_DISABLE_I ? GI_MASK : pins_t'(0);
        next_lad_oe_n  = GLOBAL_OUTPUT_DISABLE_I || !lad_drive;
        next_cpu_run   = (next_seq_state == S_RUN);
    end

    // Reset pin presets the pins at once, ahead of the synchroniser
    always_ff @(posedge MCLK_I or negedge ARST_N_I or negedge RESET_N_I) begin
        if (!ARST_N_I || !RESET_N_I) begin
            PINS_O <= PINS_RESET;
        end else begin
            PINS_O <= next_pins;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            PINS_OE_N_O <= pins_t'(0);
            LAD_O       <= 32'h0000_0000;
            LAD_OE_N_O  <= 1'b1;
            SYNC_OE_N_O <= 3'h7; // Sync pins never driven here
            CPU_RUN_O   <= 1'b0;
            MEM_GRANT_O <= 1'b0;
        end else begin
            PINS_OE_N_O <= next_pins_oe_n;
            LAD_O       <= next_lad;
            LAD_OE_N_O  <= next_lad_oe_n;
            SYNC_OE_N_O <= 3'h7;
            CPU_RUN_O   <= next_cpu_run;
            MEM_GRANT_O <= next_cpu_run;
        end
    end

endmodule : reset_init_sequencer

// File: tb/mem_model.sv
`timescale 1ns/10ps
module mem_model
    import reset_init_pkg::*;
(
    // Pins from the device
    input  wire logic        clk_i,
    input  wire pins_t       pins_i,
    input  wire logic        bus16_i,
    input  wire logic        slow_i,
    input  wire logic [31:0] vec_i,
    // Answer to the device
    output logic      [31:0] lad_o,
    output logic             wait_n_o
);
    logic        col;
    logic        half;
    logic        waited;
    logic [31:0] data;
    // Read column phase: row strobe and a column strobe low, buffer inward;
    // the page-mode gap has every column strobe high and must not flip the half
    assign col      = !pins_i.row_strobe && pins_i.buffer_dir_in && pins_i.col_strobe != CAS_NONE;
    assign data     = bus16_i ? {2{half ? vec_i[31:16] : vec_i[15:0]}} : vec_i;
    // Released bus shows the inverse, never a stale copy
    assign lad_o    = col ? data : ~data;
    assign wait_n_o = !(slow_i && col && !waited);
    // Half select flips per accepted column; one wait per column when slow
    always_ff @(posedge clk_i) begin
        half   <= pins_i.row_strobe ? 1'b0 : half ^ (col && wait_n_o);
        waited <= col && !waited;
    end
endmodule : mem_model

// File: tb/reset_init_monitor.sv
`timescale 1ns/10ps
module reset_init_monitor
    import reset_init_pkg::*;
(
    // Clock, resets and straps
    input wire logic        MCLK_I,
    input wire logic        ARST_N_I,
    input wire logic        RESET_N_I,
    input wire logic        HOST_CHIP_SELECT_N_I,
    input wire logic        GLOBAL_OUTPUT_DISABLE_I,
    // Watched outputs
    input wire pins_t       PINS_O,
    input wire pins_t       PINS_OE_N_O,
    input wire logic [31:0] LAD_O,
    input wire logic        LAD_OE_N_O,
    input wire logic        CPU_RUN_O,
    input wire logic        MEM_GRANT_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    logic       ras_q;
    logic       ref_go;
    logic [3:0] ref_cnt;
    logic [7:0] gap;
    // Refresh start is a row strobe fall with every column strobe low
    assign ref_go = ras_q && !PINS_O.row_strobe && PINS_O.col_strobe == CAS_ALL;
    // Refresh count since the reset pin and cycles between starts, saturating
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ras_q   <= 1'b1;
            ref_cnt <= 4'h0;
            gap     <= 8'h00;
        end else begin
            ras_q   <= PINS_O.row_strobe;
            gap     <= ref_go ? 8'h01 : gap + {7'h0, gap != 8'hFF};
            ref_cnt <= !RESET_N_I ? 4'h0 : ref_cnt + {3'h0, ref_go && ref_cnt != 4'hF};
        end
    end
    chk_ras_reset: assert property (!RESET_N_I |-> PINS_O.row_strobe)
        else $error("row strobe low in reset");
    chk_pin_levels: assert property (!RESET_N_I |-> PINS_O == PINS_RESET)
        else $error("reset pin levels");
    chk_bus_float: assert property (!RESET_N_I [*5] |-> LAD_OE_N_O && !CPU_RUN_O)
        else $error("bus driven in reset");
    chk_gi_float: assert property (GLOBAL_OUTPUT_DISABLE_I [*2] |-> LAD_OE_N_O && (PINS_OE_N_O & GI_MASK) == GI_MASK)
        else $error("pins not floated");
    chk_init_refresh: assert property ($rose(MEM_GRANT_O) |-> ref_cnt >= 4'h8)
        else $error("grant before init refreshes");
    chk_refresh_rate: assert property (ref_go && ref_cnt >= 4'h9 && !CPU_RUN_O && HOST_CHIP_SELECT_N_I |-> gap == 8'h20)
        else $error("refresh spacing");
    chk_cycle_order: assert property ($fell(PINS_O.address_latch_strobe) |-> PINS_O.row_strobe ##1 !PINS_O.row_strobe ##1 LAD_OE_N_O && !PINS_O.row_strobe)
        else $error("memory cycle order");
    chk_addr_phase: assert property (!PINS_O.address_latch_strobe |-> !LAD_OE_N_O && LAD_O == {VEC_BIT_ADDR[31:4], STS_VEC_FETCH})
        else $error("address phase value");
    cov_boot: cover property ($rose(MEM_GRANT_O));
    cov_float: cover property (GLOBAL_OUTPUT_DISABLE_I [*2]);
    cov_periodic: cover property (ref_go && ref_cnt >= 4'h9);
endmodule : reset_init_monitor
bind reset_init_sequencer reset_init_monitor i_mon (.*);

// File: tb/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import reset_init_pkg::*;
;
    logic        MCLK_I = 0, ARST_N_I = 0, RESET_N_I = 0, HOST_CHIP_SELECT_N_I = 1;
    logic        GLOBAL_OUTPUT_DISABLE_I = 0, BUS16_I = 0, WR_I = 0, RD_I = 0, slow = 0;
    logic        MEM_WAIT_N_I, LAD_OE_N_O, CPU_RUN_O, MEM_GRANT_O;
    logic [31:0] LAD_I, LAD_O, RDATA_O, WDATA_I = 0, vec = 32'h1234_567B;
    logic [7:0]  ADDR_I = 0;
    logic [2:0]  SYNC_OE_N_O;
    pins_t       PINS_O, PINS_OE_N_O;
    int          num_errors = 0, tests_run = 0, cyc = 0;
    reset_init_sequencer i_dut (.*);
    mem_model i_mem (.clk_i(MCLK_I), .pins_i(PINS_O), .bus16_i(BUS16_I), .slow_i(slow), .vec_i(vec),
                     .lad_o(LAD_I), .wait_n_o(MEM_WAIT_N_I));
    // Clock and hang guard
    always #20 MCLK_I = ~MCLK_I;
    always @(posedge MCLK_I) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    task wrap_up();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Register port: one-cycle strobes, read data the cycle after
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK_I);
        {ADDR_I, WDATA_I, WR_I} <= {a, d, 1'b1};
        @(posedge MCLK_I);
        WR_I <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge MCLK_I);
        {ADDR_I, RD_I} <= {a, 1'b1};
        @(posedge MCLK_I);
        RD_I <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, RDATA_O & m);
    endtask : rd
    // Bounded wait for the core to start
    task wait_run();
        for (int n = 0; n < 3000 && CPU_RUN_O !== 1'b1; n++) @(posedge MCLK_I);
        chk("run", 32'h1, {31'h0, CPU_RUN_O});
    endtask : wait_run
    initial begin
        repeat (6) @(posedge MCLK_I);
        ARST_N_I <= 1'b1;
        repeat (4) @(posedge MCLK_I);
        RESET_N_I <= 1'b1;
        repeat (300) @(posedge MCLK_I);
        #1 chk("halted", 32'h0, {31'h0, CPU_RUN_O});
        chk("sync float", 32'h7, {29'h0, SYNC_OE_N_O});
        rd(OFS_HOST_CTL, 32'h0000_8000);
        rd(OFS_CONFIG, 32'h0);
        rd(OFS_REFRESH, 32'h0);
        rd(OFS_PRESENT, PRESENT_RESET);
        // Quarter phase counts from the synced release edge, so it is known here
        rd(OFS_SEQ, 32'h0000_E432);
        rd(8'h40, 32'h0);
        GLOBAL_OUTPUT_DISABLE_I <= 1'b1;
        repeat (4) @(posedge MCLK_I);
        GLOBAL_OUTPUT_DISABLE_I <= 1'b0;
        wr(OFS_HOST_CTL, 32'h0);
        wait_run();
        rd(OFS_PC, {vec[31:4], 4'h0});
        rd(OFS_STATUS, STATUS_RESET);
        rd(OFS_CONFIG, {28'h0, vec[3:0]});
        wr(OFS_CONFIG, 32'h0000_AB00);
        rd(OFS_CONFIG, {16'h0, 8'hAB, 4'h0, vec[3:0]});
        $display("test halt boot done");
        // Long reset, 16-bit slow memory, self boot
        {HOST_CHIP_SELECT_N_I, BUS16_I, slow, RESET_N_I} <= 4'h6;
        vec <= 32'h0ABC_DEF4;
        repeat (20) @(posedge MCLK_I);
        RESET_N_I <= 1'b1;
        repeat (130) @(posedge MCLK_I);
        #1 chk("internal reset", 32'h0, {31'h0, CPU_RUN_O});
        wait_run();
        rd(OFS_HOST_CTL, 32'h0);
        rd(OFS_PC, {vec[31:4], 4'h0});
        rd(OFS_CONFIG, {28'h0, vec[3:0]});
        wr(OFS_CONFIG, 32'h0000_0005);
        rd(OFS_CONFIG, 32'h0000_0005);
        $display("test long reset done");
        wrap_up();
    end
endmodule : tb_top
